/* mort_pkg.sv */
package mort_pkg;
   // register map: index per option register number, byte address is four times it
   localparam logic [7:0] MORT_IDX_OPTIONS = 8'h0E;
   localparam logic [7:0] MORT_IDX_TEST = 8'h10;
   localparam logic [7:0] MORT_IDX_DURATION = 8'h12;
   localparam logic [7:0] MORT_IDX_CMD = 8'h40;
   localparam logic [9:0] MORT_ADDR_OPTIONS = 10'h038;
   localparam logic [9:0] MORT_ADDR_TEST = 10'h040;
   localparam logic [9:0] MORT_ADDR_DURATION = 10'h048;
   localparam logic [9:0] MORT_ADDR_CMD = 10'h100;
   // option register fields
   localparam int MORT_OPT_ECHO = 1;
   localparam int MORT_OPT_QUIET = 2;
   localparam int MORT_OPT_VERBOSE = 3;
   localparam int MORT_OPT_VOICE = 5;
   localparam int MORT_OPT_ORIG = 7;
   localparam logic [7:0] MORT_OPT_MASK = 8'hAE;
   localparam logic [7:0] MORT_OPT_RESET = 8'hAA;
   // test status fields
   localparam int MORT_TST_LDL = 0;
   localparam int MORT_TST_LDATA = 2;
   localparam int MORT_TST_FAR = 3;
   localparam int MORT_TST_RDL = 4;
   localparam int MORT_TST_RDL_ST = 5;
   localparam int MORT_TST_LDL_ST = 6;
   localparam logic [7:0] MORT_TST_MASK = 8'h7D;
   localparam logic [7:0] MORT_TST_RESET = 8'h00;
   localparam logic [7:0] MORT_DUR_RESET = 8'h00;
   // timing
   localparam int MORT_CLK_HZ = 25000000;
   localparam int MORT_SEC_MS = 1000;
   localparam int MORT_TICK_MS = 1000;
   localparam int MORT_TICK_CYCLES = MORT_CLK_HZ / MORT_SEC_MS * MORT_TICK_MS;
   // command codes, written to the command register
   typedef enum logic [7:0] {
      MORT_CMD_NONE = 8'h00,
      MORT_CMD_ECHO_OFF = 8'h01,
      MORT_CMD_ECHO_ON = 8'h02,
      MORT_CMD_QUIET_OFF = 8'h03,
      MORT_CMD_QUIET_ON = 8'h04,
      MORT_CMD_SHORT = 8'h05,
      MORT_CMD_VERBOSE = 8'h06,
      MORT_CMD_DATA_CALL = 8'h07,
      MORT_CMD_VOICE_CALL = 8'h08,
      MORT_CMD_ANSWER = 8'h09,
      MORT_CMD_DIAL = 8'h0A,
      MORT_CMD_LOOP_STOP = 8'h10,
      MORT_CMD_LDL_A = 8'h11,
      MORT_CMD_LDL_B = 8'h12,
      MORT_CMD_LDATA = 8'h13,
      MORT_CMD_FAR_GRANT = 8'h14,
      MORT_CMD_FAR_DENY = 8'h15,
      MORT_CMD_RDL = 8'h16,
      MORT_CMD_RDL_ST = 8'h17,
      MORT_CMD_LDL_ST = 8'h18
   } mort_cmd_t;
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mort_bus_t;
endpackage : mort_pkg

/* mort_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module mort_sync (
   input wire logic clk_i,       // clock
   input wire logic sys_rst_i,   // async reset
   input wire logic async_i,     // raw input
   output logic level_o          // filtered level
);
   logic [2:0] sh_reg;
   logic [2:0] sh_next;
   logic lvl_reg;
   logic lvl_next;
   always_comb begin
      sh_next = {sh_reg[1:0], async_i};
      lvl_next = lvl_reg;
      // a change counts once stages two and three agree
      if (sh_reg[1] == sh_reg[2]) begin
         lvl_next = sh_reg[2];
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sh_reg <= 3'h0;
         lvl_reg <= 1'b0;
      end else begin
         sh_reg <= sh_next;
         lvl_reg <= lvl_next;
      end
   end
   assign level_o = lvl_reg;
endmodule : mort_sync
`default_nettype wire

/* mort_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module mort_tick #(
   parameter int CYCLES = 25000000
) (
   input wire logic clk_i,       // clock
   input wire logic sys_rst_i,   // async reset
   input wire logic restart_i,   // restart the period
   output logic tick_o           // one-cycle pulse per period
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic tick_reg;
   logic tick_next;
   always_comb begin
      cnt_next = cnt_reg + 32'h1;
      tick_next = 1'b0;
      if (restart_i) begin
         cnt_next = 32'h0;
      end else if (cnt_reg == 32'(CYCLES - 1)) begin
         cnt_next = 32'h0;
         tick_next = 1'b1;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 32'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end
   assign tick_o = tick_reg;
endmodule : mort_tick
`default_nettype wire

/* mort_regs.sv */
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - option bits 0, 4 and 6 always read zero.
// - option bit 1 is command echo, default one, set by echo commands.
// - option bit 2 suppresses result codes, default zero, quiet commands.
// - option bit 3 picks word result codes, default one, verbose commands.
// - option bit 5 holds dialing selection, default one.
// - bit 5 zero marks a data call, one marks a voice call.
// - option bit 7 is originate mode, default one, answer and dial commands.
// - option register reads AA after reset.
// - registers are eight bits wide; only the duration register uses all eight.
// - test bit 0 set during local digital loop, two commands start it.
// - test bit 2 set during local data loop test.
// - test bit 3 set while far-requested loop active, grant and deny commands.
// - test bit 4 set during locally requested remote digital loop.
// - test bit 5 set during remote digital loop with self-test.
// - test bit 6 set during local digital loop with self-test.
// - test bits 1 and 7 always read zero.
// - at most one test active at any moment.
// - stop command ends local tests and clears test register.
// - local tests end after duration seconds; zero means run until stopped.
module mort_regs
   import mort_pkg::*;
#(
   parameter int TICK_CYCLES = MORT_TICK_CYCLES
) (
   input wire logic clk_i,            // 25 MHz clock
   input wire logic sys_rst_i,        // async reset, active high
   input wire logic [9:0] addr_i,     // byte address
   input wire logic [31:0] wdata_i,   // write data
   input wire logic wr_i,             // write strobe
   input wire logic rd_i,             // read strobe
   input wire logic far_loop_req_i,   // far end asks for a digital loop (pin)
   output logic [31:0] rdata_o,       // read data, cycle after read strobe
   output logic echo_en_o,            // echo typed characters
   output logic result_quiet_o,       // suppress result codes
   output logic result_verbose_o,     // word result codes
   output logic voice_call_o,         // call type voice, else data
   output logic originate_o,          // originate mode, else answer
   output logic [7:0] test_state_o,   // live loopback test state
   output logic far_req_pending_o     // far loop request awaiting grant
);
   mort_bus_t bus;
   logic far_req;
   logic tick;
   logic [7:0] opt_reg;
   logic [7:0] opt_next;
   logic [7:0] tst_reg;
   logic [7:0] tst_next;
   logic [7:0] dur_reg;
   logic [7:0] dur_next;
   logic [7:0] secs_reg;
   logic [7:0] secs_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic pend_reg;
   logic pend_next;
   logic cmd_wr;
   logic local_test;
   logic start_test;
   logic [7:0] start_bits;

   assign bus.addr = addr_i;
   assign bus.wdata = wdata_i[7:0];
   assign bus.wr = wr_i;
   assign bus.rd = rd_i;
   assign cmd_wr = bus.wr && (bus.addr == MORT_ADDR_CMD);
   // the far-end loop is not counted as locally initiated
   assign local_test = |(tst_reg & ~(8'h01 << MORT_TST_FAR));

   mort_sync u_far_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(far_loop_req_i),
      .level_o(far_req)
   );

   // the second count restarts with each test so the first second is whole
   mort_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_sec_tick (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .restart_i(start_test),
      .tick_o(tick)
   );

   // option register
   always_comb begin
      opt_next = opt_reg;
      if (bus.wr && (bus.addr == MORT_ADDR_OPTIONS)) begin
         opt_next = bus.wdata & MORT_OPT_MASK;
      end else if (cmd_wr) begin
         case (mort_cmd_t'(bus.wdata))
            MORT_CMD_ECHO_OFF: opt_next[MORT_OPT_ECHO] = 1'b0;
            MORT_CMD_ECHO_ON: opt_next[MORT_OPT_ECHO] = 1'b1;
            MORT_CMD_QUIET_OFF: opt_next[MORT_OPT_QUIET] = 1'b0;
            MORT_CMD_QUIET_ON: opt_next[MORT_OPT_QUIET] = 1'b1;
            MORT_CMD_SHORT: opt_next[MORT_OPT_VERBOSE] = 1'b0;
            MORT_CMD_VERBOSE: opt_next[MORT_OPT_VERBOSE] = 1'b1;
            MORT_CMD_DATA_CALL: opt_next[MORT_OPT_VOICE] = 1'b0;
            MORT_CMD_VOICE_CALL: opt_next[MORT_OPT_VOICE] = 1'b1;
            MORT_CMD_ANSWER: opt_next[MORT_OPT_ORIG] = 1'b0;
            MORT_CMD_DIAL: opt_next[MORT_OPT_ORIG] = 1'b1;
            default: opt_next = opt_reg;
         endcase
      end
   end

   // test starts; a new request is refused while any test runs
   always_comb begin
      start_bits = 8'h00;
      if (cmd_wr && (tst_reg == 8'h00)) begin
         case (mort_cmd_t'(bus.wdata))
            MORT_CMD_LDL_A: start_bits[MORT_TST_LDL] = 1'b1;
            MORT_CMD_LDL_B: start_bits[MORT_TST_LDL] = 1'b1;
            MORT_CMD_LDATA: start_bits[MORT_TST_LDATA] = 1'b1;
            MORT_CMD_FAR_GRANT: start_bits[MORT_TST_FAR] = pend_reg;
            MORT_CMD_RDL: start_bits[MORT_TST_RDL] = 1'b1;
            MORT_CMD_RDL_ST: start_bits[MORT_TST_RDL_ST] = 1'b1;
            MORT_CMD_LDL_ST: start_bits[MORT_TST_LDL_ST] = 1'b1;
            default: start_bits = 8'h00;
         endcase
      end
      start_test = |start_bits;
   end

   // test state, duration and far request
   always_comb begin
      tst_next = tst_reg;
      secs_next = secs_reg;
      dur_next = dur_reg;
      pend_next = pend_reg;
      if (bus.wr && (bus.addr == MORT_ADDR_DURATION)) begin
         dur_next = bus.wdata;
      end
      // a far request is only latched while it is raised; grant or deny consumes it
      if (!far_req) begin
         pend_next = 1'b0;
      end else if (!pend_reg && !tst_reg[MORT_TST_FAR]) begin
         pend_next = 1'b1;
      end
      if (start_test) begin
         tst_next = start_bits & MORT_TST_MASK;
         secs_next = 8'h00;
         pend_next = 1'b0;
      end else if (cmd_wr && (mort_cmd_t'(bus.wdata) == MORT_CMD_LOOP_STOP)) begin
         tst_next = MORT_TST_RESET;
         secs_next = 8'h00;
      end else if (cmd_wr && (mort_cmd_t'(bus.wdata) == MORT_CMD_FAR_DENY)) begin
         pend_next = 1'b0;
         tst_next[MORT_TST_FAR] = 1'b0;
      end else if (tst_reg[MORT_TST_FAR] && !far_req) begin
         tst_next[MORT_TST_FAR] = 1'b0;
      end else if (local_test && tick && (dur_reg != 8'h00)) begin
         // duration zero leaves the test running until stopped
         if (secs_reg + 8'h01 >= dur_reg) begin
            tst_next = MORT_TST_RESET;
            secs_next = 8'h00;
         end else begin
            secs_next = secs_reg + 8'h01;
         end
      end
   end

   // read path: data stands in the cycle after the strobe only
   always_comb begin
      rdata_next = 32'h0;
      if (bus.rd) begin
         case (bus.addr)
            MORT_ADDR_OPTIONS: rdata_next = {24'h0, opt_reg & MORT_OPT_MASK};
            MORT_ADDR_TEST: rdata_next = {24'h0, tst_reg & MORT_TST_MASK};
            MORT_ADDR_DURATION: rdata_next = {24'h0, dur_reg};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         opt_reg <= MORT_OPT_RESET;
         tst_reg <= MORT_TST_RESET;
         dur_reg <= MORT_DUR_RESET;
         secs_reg <= 8'h00;
         pend_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         opt_reg <= opt_next;
         tst_reg <= tst_next;
         dur_reg <= dur_next;
         secs_reg <= secs_next;
         pend_reg <= pend_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign echo_en_o = opt_reg[MORT_OPT_ECHO];
   assign result_quiet_o = opt_reg[MORT_OPT_QUIET];
   assign result_verbose_o = opt_reg[MORT_OPT_VERBOSE];
   assign voice_call_o = opt_reg[MORT_OPT_VOICE];
   assign originate_o = opt_reg[MORT_OPT_ORIG];
   assign test_state_o = tst_reg;
   assign far_req_pending_o = pend_reg;
endmodule : mort_regs
`default_nettype wire

/* mort_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mort_regs_assertions
   import mort_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic sys_rst_i, // async reset
   input wire logic [9:0] addr_i, // byte address
   input wire logic [31:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   input wire logic [31:0] rdata_o, // read data
   input wire logic echo_en_o, // echo
   input wire logic result_quiet_o, // quiet
   input wire logic result_verbose_o, // word codes
   input wire logic voice_call_o, // voice call
   input wire logic originate_o, // originate
   input wire logic [7:0] test_state_o // test state
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic cmd_wr;
   logic [7:0] cmd;
   assign cmd_wr = wr_i && addr_i == MORT_ADDR_CMD;
   assign cmd = wdata_i[7:0];
   a_opt_zero_bits: assert property (rd_i && addr_i == MORT_ADDR_OPTIONS
      |=> (rdata_o & 32'hFFFFFF51) == 32'h00000000) else $error("option unused bits set");
   a_echo_off: assert property (cmd_wr && cmd == MORT_CMD_ECHO_OFF |=> !echo_en_o)
      else $error("echo still on");
   a_quiet_on: assert property (cmd_wr && cmd == MORT_CMD_QUIET_ON |=> result_quiet_o)
      else $error("quiet not set");
   a_short_codes: assert property (cmd_wr && cmd == MORT_CMD_SHORT |=> !result_verbose_o)
      else $error("word codes still on");
   a_voice_call: assert property (cmd_wr && cmd == MORT_CMD_VOICE_CALL |=> voice_call_o)
      else $error("voice call not marked");
   a_answer_mode: assert property (cmd_wr && cmd == MORT_CMD_ANSWER |=> !originate_o)
      else $error("still originate");
   a_test_unused: assert property (test_state_o[1] == 1'b0 && test_state_o[7] == 1'b0)
      else $error("unused test bit set");
   a_one_test: assert property ($onehot0(test_state_o)) else $error("two tests active");
   a_stop_clears: assert property (cmd_wr && cmd == MORT_CMD_LOOP_STOP
      |=> test_state_o == 8'h00) else $error("stop left a test");
endmodule : mort_regs_assertions
bind mort_regs mort_regs_assertions u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .echo_en_o(echo_en_o), .result_quiet_o(result_quiet_o), .result_verbose_o(result_verbose_o),
   .voice_call_o(voice_call_o), .originate_o(originate_o), .test_state_o(test_state_o));
`default_nettype wire

/* mort_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mort_far_model (
   input wire logic clk_i, // clock
   input wire logic sys_rst_i, // async reset
   input wire logic ask_i, // bench wants a far loop
   output logic far_loop_req_o // request pin level
);
   // the far system holds its request as a level until it withdraws it
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         far_loop_req_o <= 1'b0;
      end else begin
         far_loop_req_o <= ask_i;
      end
   end
endmodule : mort_far_model
`default_nettype wire

/* mort_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module mort_regs_tb;
   import mort_pkg::*;
   logic clk_i, sys_rst_i, wr_i, rd_i, far_ask, far_req;
   logic [9:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic echo_en_o, result_quiet_o, result_verbose_o, voice_call_o, originate_o, pend;
   logic [7:0] test_state_o;
   int err_total = 0;
   int cmp_count = 0;
   // short tick so a two-second test takes twenty cycles
   mort_regs #(.TICK_CYCLES(10)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .far_loop_req_i(far_req), .rdata_o(rdata_o),
      .echo_en_o(echo_en_o), .result_quiet_o(result_quiet_o), .result_verbose_o(result_verbose_o),
      .voice_call_o(voice_call_o), .originate_o(originate_o), .test_state_o(test_state_o),
      .far_req_pending_o(pend));
   mort_far_model u_far (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ask_i(far_ask),
      .far_loop_req_o(far_req));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= {24'h000000, d};
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : bus_wr
   task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : bus_rd
   task automatic t_reset_opts();
      logic [31:0] rv;
      bus_rd(MORT_ADDR_OPTIONS, rv);
      `CHK(rv, 32'h000000AA)
      bus_wr(MORT_ADDR_OPTIONS, 8'hFF);
      bus_rd(MORT_ADDR_OPTIONS, rv);
      `CHK(rv, 32'h000000AE)
      bus_wr(MORT_ADDR_OPTIONS, 8'h00);
      bus_rd(MORT_ADDR_OPTIONS, rv);
      `CHK(rv, 32'h00000000)
      bus_wr(MORT_ADDR_TEST, 8'hFF);
      bus_rd(MORT_ADDR_TEST, rv);
      `CHK(rv, 32'h00000000)
      bus_rd(10'h3FC, rv);
      `CHK(rv, 32'h00000000)
      bus_wr(MORT_ADDR_DURATION, 8'hFF);
      bus_rd(MORT_ADDR_DURATION, rv);
      `CHK(rv, 32'h000000FF)
      bus_rd(MORT_ADDR_CMD, rv);
      `CHK(rv, 32'h00000000)
      // later tests expect the untimed default again
      bus_wr(MORT_ADDR_DURATION, 8'h00);
      bus_wr(MORT_ADDR_OPTIONS, 8'hAA);
   endtask : t_reset_opts
   task automatic t_opt_cmds();
      logic [7:0] cmd [10] = '{8'h01, 8'h02, 8'h04, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
      logic [7:0] ex [10] = '{8'hA8, 8'hAA, 8'hAE, 8'hAA, 8'hA2, 8'hAA, 8'h8A, 8'hAA, 8'h2A, 8'hAA};
      logic [31:0] rv;
      logic [4:0] pins;
      for (int i = 0; i < 10; i++) begin
         bus_wr(MORT_ADDR_CMD, cmd[i]);
         pins = {originate_o, voice_call_o, result_verbose_o, result_quiet_o, echo_en_o};
         bus_rd(MORT_ADDR_OPTIONS, rv);
         `CHK(rv, {24'h000000, ex[i]})
         `CHK(pins, {ex[i][7], ex[i][5], ex[i][3:1]})
      end
      // an unknown command code must leave the options alone
      bus_wr(MORT_ADDR_CMD, 8'h3C);
      bus_rd(MORT_ADDR_OPTIONS, rv);
      `CHK(rv, 32'h000000AA)
   endtask : t_opt_cmds
   task automatic t_loop_tests();
      logic [7:0] st [6] = '{8'h11, 8'h12, 8'h13, 8'h16, 8'h17, 8'h18};
      logic [7:0] ex [6] = '{8'h01, 8'h01, 8'h04, 8'h10, 8'h20, 8'h40};
      logic [31:0] rv;
      for (int i = 0; i < 6; i++) begin
         bus_wr(MORT_ADDR_CMD, st[i]);
         bus_rd(MORT_ADDR_TEST, rv);
         `CHK(rv, {24'h000000, ex[i]})
         bus_wr(MORT_ADDR_CMD, (i == 2) ? 8'h11 : 8'h13);
         `CHK(test_state_o, ex[i])
         bus_wr(MORT_ADDR_CMD, 8'h10);
         `CHK(test_state_o, 8'h00)
      end
   endtask : t_loop_tests
   task automatic t_far();
      bus_wr(MORT_ADDR_CMD, 8'h14);
      `CHK(test_state_o, 8'h00)
      far_ask <= 1'b1;
      repeat (10) @(posedge clk_i);
      #1 `CHK(pend, 1'b1)
      bus_wr(MORT_ADDR_CMD, 8'h14);
      `CHK(test_state_o, 8'h08)
      bus_wr(MORT_ADDR_CMD, 8'h13);
      `CHK(test_state_o, 8'h08)
      bus_wr(MORT_ADDR_CMD, 8'h15);
      `CHK(test_state_o, 8'h00)
      // the request still stands, so it is pending again and can be granted
      repeat (2) @(posedge clk_i);
      bus_wr(MORT_ADDR_CMD, 8'h14);
      `CHK(test_state_o, 8'h08)
      far_ask <= 1'b0;
      repeat (10) @(posedge clk_i);
      #1 `CHK(test_state_o, 8'h00)
      `CHK(pend, 1'b0)
   endtask : t_far
   task automatic t_duration();
      int n = 0;
      bus_wr(MORT_ADDR_CMD, 8'h11);
      repeat (30) @(posedge clk_i);
      #1 `CHK(test_state_o, 8'h01)
      bus_wr(MORT_ADDR_CMD, 8'h10);
      bus_wr(MORT_ADDR_DURATION, 8'h02);
      bus_wr(MORT_ADDR_CMD, 8'h18);
      while (test_state_o !== 8'h00 && n < 60) begin
         @(posedge clk_i);
         #1 n++;
      end
      `CHK(n >= 15 && n <= 25, 1'b1)
   endtask : t_duration
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   initial begin
      sys_rst_i = 1'b1;
      addr_i = 10'h000;
      wdata_i = 32'h00000000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      far_ask = 1'b0;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset_opts();
      t_opt_cmds();
      t_loop_tests();
      t_far();
      t_duration();
      close_out();
   end
   // whole run is about 210 cycles; 3000 means a hang
   initial begin
      #(40 * 3000);
      err_total++;
      close_out();
   end
endmodule : mort_regs_tb
`default_nettype wire
